// *** design/lsli_top.sv ***
// lsli_top: power and traffic led indication and script start/stop events
// assumes all flag inputs are synchronous to mclk except the power pins
//
// Summary of operation
// (RULE1) logger mode: can power only, no usb
// (RULE2) fault: same traffic pattern, power names fault
// (RULE3) fw/hw fault: fast waver both leds
// (RULE4) battery fault: power fast, traffic slow waver
// (RULE5) disk fault: yellow on, red slow blink
// (RULE6) config fault: yellow on, red fast blink
// (RULE7) script load failure shown as config fault
// (RULE8) armed on, logging fast, stopped slow green
// (RULE9) no fault: traffic shows channel bus status
// (RULE10) running script may override any led
// (RULE11) start event on four listed causes
// (RULE12) stop event on four listed causes
// (RULE13) power-off stop waits full run-on interval
// (RULE14) blink halves equal, fast above slow
// (RULE15) waver lights second colour when dark
// (RULE16) faults beat state, fw/hw fault highest
// (RULE17) blink rates from programmable clock dividers
`default_nettype none
module lsli_top #(
  parameter int NCHAN = 5,
  parameter int SLOW_HALF = lsli_pkg::SLOW_HALF_CYC,
  parameter int FAST_HALF = lsli_pkg::FAST_HALF_CYC,
  parameter int RUNON = lsli_pkg::RUNON_CYC
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic nrst,
  input wire logic clk_en,
  // power pins, asynchronous
  input wire logic can_pwr_pin,
  input wire logic usb_pwr_pin,
  // fault flags
  input wire logic fault_fwhw,
  input wire logic fault_batt,
  input wire logic fault_disk,
  input wire logic fault_cfg,
  input wire logic script_load_fail,
  // logging state, one-hot armed/active/stopped
  input wire logic [2:0] log_state,
  // per channel bus status led codes
  input wire logic [2*NCHAN-1:0] bus_led,
  // script led override: enable and value per led, power at index 0
  input wire logic [NCHAN:0] scr_ovr_en,
  input wire logic [2*NCHAN+1:0] scr_ovr_led,
  // host and script commands, one-cycle pulses
  input wire logic host_script_start_call,
  input wire logic host_script_stop_call,
  input wire logic script_start_req,
  input wire logic script_stop_req,
  input wire logic host_mode_select_call,
  input wire logic logger_mode_selector,
  input wire logic interface_mode_selector,
  // led outputs: bit0 first colour, bit1 second colour
  output logic [1:0] power_led,
  output logic [2*NCHAN-1:0] traffic_led,
  // mode and events
  output logic logger_mode,
  output logic start_evt,
  output logic stop_evt
);
  lsli_tick_if tick ();

  lsli_blink_div #(.SLOW_HALF(SLOW_HALF), .FAST_HALF(FAST_HALF)) u_div (
    .mclk(mclk),
    .nrst(nrst),
    .clk_en(clk_en),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers for the power pins
  logic can_s1_ff, can_s2_ff, usb_s1_ff, usb_s2_ff;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      can_s1_ff <= 1'b0;
      can_s2_ff <= 1'b0;
      usb_s1_ff <= 1'b0;
      usb_s2_ff <= 1'b0;
    end else if (clk_en) begin
      can_s1_ff <= can_pwr_pin;
      can_s2_ff <= can_s1_ff;
      usb_s1_ff <= usb_pwr_pin;
      usb_s2_ff <= usb_s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // led pattern helpers
  function automatic logic [1:0] blink(input logic [1:0] col, input logic ph);
    blink = ph ? col : lsli_pkg::LED_OFF; // (RULE14)
  endfunction

  function automatic logic [1:0] waver(input logic ph);
    waver = ph ? lsli_pkg::LED_C1 : lsli_pkg::LED_C2; // (RULE15)
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // mode, events and run-on state
  logic lmode_ff, nxt_lmode;
  logic usb_d_ff, nxt_usb_d;
  logic can_d_ff, nxt_can_d;
  logic runon_ff, nxt_runon;
  logic [lsli_pkg::RUNON_W-1:0] ron_cnt_ff, nxt_ron_cnt;
  logic start_ff, nxt_start;
  logic stop_ff, nxt_stop;
  logic pwr_on_mode;

  // logger mode when can power present and usb absent
  assign pwr_on_mode = can_s2_ff & ~usb_s2_ff; // (RULE1)

  // next mode, event and run-on values
  always_comb begin
    nxt_usb_d = usb_s2_ff;
    nxt_can_d = can_s2_ff;
    nxt_lmode = lmode_ff;
    nxt_runon = runon_ff;
    nxt_ron_cnt = ron_cnt_ff;
    nxt_start = 1'b0;
    nxt_stop = 1'b0;
    // power-up into logger mode
    if (pwr_on_mode && !(can_d_ff && !usb_d_ff)) begin
      nxt_lmode = 1'b1; // (RULE1)
      nxt_start = 1'b1; // (RULE11)
      nxt_runon = 1'b0;
    end
    if (host_script_start_call || script_start_req) begin
      nxt_start = 1'b1; // (RULE11)
    end
    if (host_mode_select_call && logger_mode_selector) begin
      nxt_lmode = 1'b1;
      nxt_start = 1'b1; // (RULE11)
    end
    if (host_script_stop_call || script_stop_req) begin
      nxt_stop = 1'b1; // (RULE12)
    end
    if (host_mode_select_call && interface_mode_selector) begin
      nxt_lmode = 1'b0;
      nxt_stop = 1'b1; // (RULE12)
    end
    if (usb_s2_ff != usb_d_ff) begin
      nxt_lmode = pwr_on_mode;
      nxt_stop = 1'b1; // (RULE12)
      nxt_runon = 1'b0;
    end
    // logger power lost: count down run-on before stopping
    if (lmode_ff && !can_s2_ff && can_d_ff && !usb_s2_ff) begin
      nxt_runon = 1'b1; // (RULE13)
      nxt_ron_cnt = lsli_pkg::RUNON_W'(RUNON);
    end else if (runon_ff) begin
      if (ron_cnt_ff <= lsli_pkg::RUNON_W'(1)) begin
        nxt_runon = 1'b0;
        nxt_lmode = 1'b0;
        nxt_stop = 1'b1; // (RULE13)
      end else begin
        nxt_ron_cnt = ron_cnt_ff - lsli_pkg::RUNON_W'(1);
      end
    end
  end

  // register mode and events
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      usb_d_ff <= 1'b0;
      can_d_ff <= 1'b0;
      lmode_ff <= 1'b0;
      runon_ff <= 1'b0;
      ron_cnt_ff <= '0;
      start_ff <= 1'b0;
      stop_ff <= 1'b0;
    end else if (clk_en) begin
      usb_d_ff <= nxt_usb_d;
      can_d_ff <= nxt_can_d;
      lmode_ff <= nxt_lmode;
      runon_ff <= nxt_runon;
      ron_cnt_ff <= nxt_ron_cnt;
      start_ff <= nxt_start;
      stop_ff <= nxt_stop;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // fault priority selection
  lsli_pkg::lsli_ind_t ind;
  always_comb begin
    if (!lmode_ff) ind = lsli_pkg::LSLI_IND_IDLE;
    else if (fault_fwhw) ind = lsli_pkg::LSLI_IND_FWHW; // (RULE16)
    else if (fault_batt) ind = lsli_pkg::LSLI_IND_BATT; // (RULE16)
    else if (fault_disk) ind = lsli_pkg::LSLI_IND_DISK; // (RULE16)
    else if (fault_cfg || script_load_fail) ind = lsli_pkg::LSLI_IND_CFG; // (RULE7)
    else ind = lsli_pkg::LSLI_IND_NONE;
  end

  ////////////////////////////////////////////////////////////////////////
  // next led values
  logic [1:0] pled_ff, nxt_pled;
  logic [2*NCHAN-1:0] tled_ff, nxt_tled;
  logic [1:0] all_tled;
  logic fault_on;

  always_comb begin
    fault_on = 1'b1;
    nxt_pled = lsli_pkg::LED_OFF;
    all_tled = lsli_pkg::LED_OFF;
    case (ind)
      lsli_pkg::LSLI_IND_FWHW: begin
        nxt_pled = waver(tick.fast_ph); // (RULE3)
        all_tled = waver(tick.fast_ph); // (RULE3)
      end
      lsli_pkg::LSLI_IND_BATT: begin
        nxt_pled = waver(tick.fast_ph); // (RULE4)
        all_tled = waver(tick.slow_ph); // (RULE4)
      end
      lsli_pkg::LSLI_IND_DISK: begin
        nxt_pled = lsli_pkg::LED_C2; // (RULE5)
        all_tled = blink(lsli_pkg::LED_C2, tick.slow_ph); // (RULE5)
      end
      lsli_pkg::LSLI_IND_CFG: begin
        nxt_pled = lsli_pkg::LED_C2; // (RULE6)
        all_tled = blink(lsli_pkg::LED_C2, tick.fast_ph); // (RULE6)
      end
      lsli_pkg::LSLI_IND_NONE: begin
        fault_on = 1'b0;
        case (log_state)
          lsli_pkg::LSLI_LOG_ACTIVE: nxt_pled = blink(lsli_pkg::LED_C1, tick.fast_ph); // (RULE8)
          lsli_pkg::LSLI_LOG_STOPPED: nxt_pled = blink(lsli_pkg::LED_C1, tick.slow_ph); // (RULE8)
          default: nxt_pled = lsli_pkg::LED_C1; // (RULE8)
        endcase
      end
      default: begin
        fault_on = 1'b0;
        nxt_pled = lsli_pkg::LED_OFF;
      end
    endcase
    // common fault pattern or own bus status per channel
    for (int i = 0; i < NCHAN; i++) begin
      nxt_tled[2*i +: 2] = fault_on ? all_tled : bus_led[2*i +: 2]; // (RULE2) (RULE9)
    end
    // script overrides only where it asks to
    if (scr_ovr_en[0]) nxt_pled = scr_ovr_led[1:0]; // (RULE10)
    for (int i = 0; i < NCHAN; i++) begin
      if (scr_ovr_en[i+1]) nxt_tled[2*i +: 2] = scr_ovr_led[2*i+2 +: 2]; // (RULE10)
    end
  end

  // register leds
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pled_ff <= lsli_pkg::LED_OFF;
      tled_ff <= '0;
    end else if (clk_en) begin
      pled_ff <= nxt_pled;
      tled_ff <= nxt_tled;
    end
  end

  assign power_led = pled_ff;
  assign traffic_led = tled_ff;
  assign logger_mode = lmode_ff;
  assign start_evt = start_ff;
  assign stop_evt = stop_ff;
endmodule
`default_nettype wire

// *** design/lsli_pkg.sv ***
// lsli_pkg: shared constants and types for the logger status led indicator
// assumes a 10 MHz system clock; nothing else
`default_nettype none
package lsli_pkg;
  // system clock period in ns
  localparam int CLK_PERIOD_NS = 100;
  // blink half periods in ms
  localparam int SLOW_HALF_MS = 500;
  localparam int FAST_HALF_MS = 125;
  // derived half period counts in clock cycles
  localparam int SLOW_HALF_CYC = SLOW_HALF_MS * 1000000 / CLK_PERIOD_NS;
  localparam int FAST_HALF_CYC = FAST_HALF_MS * 1000000 / CLK_PERIOD_NS;
  // default run-on after logger power loss, ms
  localparam int RUNON_MS = 1000;
  localparam int RUNON_CYC = RUNON_MS * 1000000 / CLK_PERIOD_NS;
  // dual colour led codes: bit0 first colour, bit1 second colour
  localparam logic [1:0] LED_OFF = 2'h0;
  localparam logic [1:0] LED_C1 = 2'h1;
  localparam logic [1:0] LED_C2 = 2'h2;
  // bit positions of the led code
  localparam int LED_C1_BIT = 0;
  localparam int LED_C2_BIT = 1;
  // run-on counter width
  localparam int RUNON_W = 32;
  // indication selector, one-hot
  typedef enum logic [5:0] {
    LSLI_IND_NONE  = 6'b00_0001,
    LSLI_IND_FWHW  = 6'b00_0010,
    LSLI_IND_BATT  = 6'b00_0100,
    LSLI_IND_DISK  = 6'b00_1000,
    LSLI_IND_CFG   = 6'b01_0000,
    LSLI_IND_IDLE  = 6'b10_0000
  } lsli_ind_t;
  // logging state as seen by the power led, one-hot
  typedef enum logic [2:0] {
    LSLI_LOG_ARMED   = 3'b001,
    LSLI_LOG_ACTIVE  = 3'b010,
    LSLI_LOG_STOPPED = 3'b100
  } lsli_log_t;
endpackage
`default_nettype wire

// *** design/lsli_tick_if.sv ***
// lsli_tick_if: blink phase signals passed from the divider to the top
// assumes both ends share mclk
`default_nettype none
interface lsli_tick_if;
  logic slow_ph;
  logic fast_ph;
  modport src (output slow_ph, output fast_ph);
  modport dst (input slow_ph, input fast_ph);
endinterface
`default_nettype wire

// *** design/lsli_blink_div.sv ***
// lsli_blink_div: divides mclk into slow and fast blink phases
// assumes clock enable and reset from the top module
`default_nettype none
module lsli_blink_div #(
  parameter int SLOW_HALF = lsli_pkg::SLOW_HALF_CYC,
  parameter int FAST_HALF = lsli_pkg::FAST_HALF_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  input wire logic clk_en,
  // phases out
  lsli_tick_if.src tick
);
  logic [31:0] slow_cnt_ff, nxt_slow_cnt;
  logic [31:0] fast_cnt_ff, nxt_fast_cnt;
  logic slow_ph_ff, nxt_slow_ph;
  logic fast_ph_ff, nxt_fast_ph;

  ////////////////////////////////////////////////////////////////////////
  // equal lit and dark halves, two programmable dividers
  always_comb begin
    nxt_slow_cnt = slow_cnt_ff + 32'h0000_0001;
    nxt_slow_ph = slow_ph_ff;
    nxt_fast_cnt = fast_cnt_ff + 32'h0000_0001;
    nxt_fast_ph = fast_ph_ff;
    if (slow_cnt_ff >= 32'(SLOW_HALF - 1)) begin // (RULE14) (RULE17)
      nxt_slow_cnt = 32'h0000_0000;
      nxt_slow_ph = ~slow_ph_ff;
    end
    if (fast_cnt_ff >= 32'(FAST_HALF - 1)) begin // (RULE14) (RULE17)
      nxt_fast_cnt = 32'h0000_0000;
      nxt_fast_ph = ~fast_ph_ff;
    end
  end

  // register the dividers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      slow_cnt_ff <= 32'h0000_0000;
      fast_cnt_ff <= 32'h0000_0000;
      slow_ph_ff <= 1'b1;
      fast_ph_ff <= 1'b1;
    end else if (clk_en) begin
      slow_cnt_ff <= nxt_slow_cnt;
      fast_cnt_ff <= nxt_fast_cnt;
      slow_ph_ff <= nxt_slow_ph;
      fast_ph_ff <= nxt_fast_ph;
    end
  end

  assign tick.slow_ph = slow_ph_ff;
  assign tick.fast_ph = fast_ph_ff;
endmodule
`default_nettype wire

// *** sim/lsli_checker.sv ***
// lsli_checker: concurrent checks on the status led top ports
// assumes a bind from the bench top, single clock mclk, async nrst
`default_nettype none
module lsli_chk #(
  parameter int NCHAN = 5
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // power and fault inputs
  input wire logic usb_pwr_pin,
  input wire logic fault_fwhw,
  input wire logic fault_batt,
  input wire logic fault_disk,
  input wire logic fault_cfg,
  input wire logic script_load_fail,
  // state, bus status, overrides
  input wire logic [2:0] log_state,
  input wire logic [2*NCHAN-1:0] bus_led,
  input wire logic [NCHAN:0] scr_ovr_en,
  input wire logic [2*NCHAN+1:0] scr_ovr_led,
  // commands
  input wire logic host_script_start_call,
  input wire logic host_script_stop_call,
  input wire logic script_start_req,
  input wire logic script_stop_req,
  input wire logic host_mode_select_call,
  input wire logic logger_mode_selector,
  input wire logic interface_mode_selector,
  // outputs watched
  input wire logic [1:0] power_led,
  input wire logic [2*NCHAN-1:0] traffic_led,
  input wire logic logger_mode,
  input wire logic start_evt,
  input wire logic stop_evt
);
  timeunit 1ns;
  timeprecision 1ns;
  // any fault present
  wire logic flt = fault_fwhw | fault_batt | fault_disk | fault_cfg | script_load_fail;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////
  property p_start;
    host_script_start_call || script_start_req || (host_mode_select_call && logger_mode_selector)
      |=> start_evt;
  endproperty
  a_start: assert property (p_start) else $error("start event missing");
  property p_stop;
    host_script_stop_call || script_stop_req || (host_mode_select_call && interface_mode_selector)
      |=> stop_evt;
  endproperty
  a_stop: assert property (p_stop) else $error("stop event missing");
  property p_ovr;
    scr_ovr_en[0] |=> power_led == $past(scr_ovr_led[1:0]);
  endproperty
  a_ovr: assert property (p_ovr) else $error("power override lost");
  property p_fwhw;
    logger_mode && fault_fwhw && !scr_ovr_en[0] |=> $onehot(power_led);
  endproperty
  a_fwhw: assert property (p_fwhw) else $error("fault power pattern wrong");
  property p_same;
    logger_mode && flt && scr_ovr_en == '0 |=> traffic_led == {NCHAN{traffic_led[1:0]}};
  endproperty
  a_same: assert property (p_same) else $error("traffic leds differ");
  property p_disk;
    logger_mode && !fault_fwhw && !fault_batt && fault_disk && !scr_ovr_en[0]
      |=> power_led == lsli_pkg::LED_C2;
  endproperty
  a_disk: assert property (p_disk) else $error("disk power pattern wrong");
  property p_armed;
    logger_mode && !flt && log_state == 3'h1 && !scr_ovr_en[0] |=> power_led == lsli_pkg::LED_C1;
  endproperty
  a_armed: assert property (p_armed) else $error("armed pattern wrong");
  property p_bus;
    logger_mode && !flt && scr_ovr_en == '0 |=> traffic_led == $past(bus_led);
  endproperty
  a_bus: assert property (p_bus) else $error("bus status not shown");
  property p_usb;
    usb_pwr_pin [*5] |-> !logger_mode;
  endproperty
  a_usb: assert property (p_usb) else $error("logger mode with usb");
endmodule
`default_nettype wire

// *** sim/lsli_tb.sv ***
// lsli_tb: directed bench for the status led block, two channels
// assumes short blink and run-on parameters, clk_en held high except during the freeze test
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int NC = 2;
  localparam int RUNON = 20;
  logic mclk = 0, nrst = 0, can_pwr_pin = 0, usb_pwr_pin = 0, clk_en = 1;
  logic fault_fwhw = 0, fault_batt = 0, fault_disk = 0, fault_cfg = 0, script_load_fail = 0;
  logic [2:0] log_state = 3'h1;
  logic [3:0] bus_led = 4'h9;
  logic [2:0] scr_ovr_en = 3'h0;
  logic [5:0] scr_ovr_led = 6'h0;
  logic host_script_start_call = 0, host_script_stop_call = 0, script_start_req = 0;
  logic script_stop_req = 0, host_mode_select_call = 0;
  logic logger_mode_selector = 0, interface_mode_selector = 0;
  logic [1:0] power_led;
  logic [3:0] traffic_led;
  logic logger_mode, start_evt, stop_evt;
  int errors = 0, tests_run = 0, n;
  // fault and state table: flags, state, power mask/class, traffic mask/class
  logic [19:0] rows [8] = '{20'hf_169a, 20'h7_1699, 20'h3_1415, 20'h1_1416,
                            20'h0_9416, 20'h0_2388, 20'h0_4348, 20'h0_1208};
  always #50 mclk = ~mclk;
  lsli_top #(.NCHAN(NC), .SLOW_HALF(8), .FAST_HALF(2), .RUNON(RUNON)) u_lsli_top (
    .mclk(mclk), .nrst(nrst), .clk_en(clk_en), .can_pwr_pin(can_pwr_pin),
    .usb_pwr_pin(usb_pwr_pin), .fault_fwhw(fault_fwhw), .fault_batt(fault_batt),
    .fault_disk(fault_disk), .fault_cfg(fault_cfg), .script_load_fail(script_load_fail),
    .log_state(log_state), .bus_led(bus_led), .scr_ovr_en(scr_ovr_en),
    .scr_ovr_led(scr_ovr_led), .host_script_start_call(host_script_start_call),
    .host_script_stop_call(host_script_stop_call), .script_start_req(script_start_req),
    .script_stop_req(script_stop_req), .host_mode_select_call(host_mode_select_call),
    .logger_mode_selector(logger_mode_selector),
    .interface_mode_selector(interface_mode_selector), .power_led(power_led),
    .traffic_led(traffic_led), .logger_mode(logger_mode), .start_evt(start_evt),
    .stop_evt(stop_evt));
  ////////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // bounded wait for an event pulse
  task automatic wait_for(input bit st, output int k);
    k = 0;
    while ((st ? stop_evt : start_evt) !== 1'b1 && k < 60) begin
      @(posedge mclk);
      #1 k++;
    end
  endtask
  // rate class from edge count over 32 samples
  function automatic logic [1:0] cls(input int t);
    return (t == 0) ? 2'h0 : (t <= 5) ? 2'h1 : 2'h2;
  endfunction
  // power-up into logger mode, then usb in and out
  task automatic t_power;
    @(posedge mclk) can_pwr_pin <= 1;
    wait_for(0, n);
    chk(n < 8, 1);
    chk(logger_mode, 1);
    @(posedge mclk) usb_pwr_pin <= 1;
    wait_for(1, n);
    chk(n < 8, 1);
    repeat (3) @(posedge mclk);
    usb_pwr_pin <= 0;
    #1 chk(logger_mode, 0);
    wait_for(1, n);
    chk(n < 8, 1);
    repeat (3) @(posedge mclk);
    $display("power test done");
  endtask
  // every fault and state pattern, measured over 32 cycles
  task automatic t_faults;
    logic [3:0] pm, tm;
    int pt, tt;
    logic [1:0] pv, tv;
    for (int r = 0; r < 8; r++) begin
      @(posedge mclk);
      {fault_fwhw, fault_batt, fault_disk, fault_cfg, script_load_fail} <= rows[r][19:15];
      log_state <= rows[r][14:12];
      repeat (3) @(posedge mclk);
      #1 pm = 0;
      tm = 0;
      pt = 0;
      tt = 0;
      pv = power_led;
      tv = traffic_led[1:0];
      repeat (32) begin
        @(posedge mclk);
        #1 pm[power_led] = 1'b1;
        tm[traffic_led[1:0]] = 1'b1;
        pt += (power_led != pv);
        tt += (traffic_led[1:0] != tv);
        pv = power_led;
        tv = traffic_led[1:0];
        if (rows[r][19:15] != 5'h0) begin
          chk(traffic_led[3:2], traffic_led[1:0]);
        end else begin
          chk(traffic_led, bus_led);
        end
      end
      chk(pm, rows[r][11:8]);
      chk(cls(pt), rows[r][7:6]);
      chk(tm, rows[r][5:2]);
      chk(cls(tt), rows[r][1:0]);
    end
    $display("fault pattern test done");
  endtask
  // clock enable low holds the blinking power led still
  task automatic t_freeze;
    logic [1:0] held;
    @(posedge mclk) log_state <= 3'h2;
    repeat (3) @(posedge mclk);
    clk_en <= 0;
    #1 held = power_led;
    repeat (6) begin
      @(posedge mclk);
      #1 chk(power_led, held);
    end
    @(posedge mclk) clk_en <= 1;
    log_state <= 3'h1;
    $display("freeze test done");
  endtask
  // script override beats a fault
  task automatic t_override;
    @(posedge mclk) fault_fwhw <= 1;
    scr_ovr_en <= 3'h7;
    scr_ovr_led <= 6'h2d;
    repeat (3) @(posedge mclk);
    #1 chk({traffic_led, power_led}, 6'h2d);
    repeat (3) @(posedge mclk);
    #1 chk({traffic_led, power_led}, 6'h2d);
    @(posedge mclk) fault_fwhw <= 0;
    scr_ovr_en <= 3'h0;
    $display("override test done");
  endtask
  // can power loss waits out the run-on
  task automatic t_runon;
    @(posedge mclk) can_pwr_pin <= 0;
    wait_for(1, n);
    chk(n >= RUNON - 1 && n <= RUNON + 4, 1);
    repeat (3) @(posedge mclk);
    #1 chk(logger_mode, 0);
    $display("run-on test done");
  endtask
  // every start and stop command
  task automatic t_cmds;
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk);
      {host_script_start_call, script_start_req, logger_mode_selector, host_script_stop_call,
       script_stop_req, interface_mode_selector} <= 6'h20 >> i;
      host_mode_select_call <= (i == 2 || i == 5);
      @(posedge mclk);
      {host_script_start_call, script_start_req, logger_mode_selector, host_script_stop_call,
       script_stop_req, interface_mode_selector} <= 6'h0;
      host_mode_select_call <= 0;
      #1 chk(i < 3 ? start_evt : stop_evt, 1);
    end
    $display("command test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // verdict
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge mclk);
    nrst <= 1;
    t_power();
    t_faults();
    t_freeze();
    t_override();
    t_runon();
    t_cmds();
    tally_and_finish();
  end
  // watchdog
  initial begin
    #300000;
    errors++;
    tally_and_finish();
  end
endmodule
bind lsli_top lsli_chk #(.NCHAN(NCHAN)) u_lsli_chk (
  .mclk(mclk), .nrst(nrst), .usb_pwr_pin(usb_pwr_pin), .fault_fwhw(fault_fwhw),
  .fault_batt(fault_batt), .fault_disk(fault_disk), .fault_cfg(fault_cfg),
  .script_load_fail(script_load_fail), .log_state(log_state), .bus_led(bus_led),
  .scr_ovr_en(scr_ovr_en), .scr_ovr_led(scr_ovr_led),
  .host_script_start_call(host_script_start_call),
  .host_script_stop_call(host_script_stop_call), .script_start_req(script_start_req),
  .script_stop_req(script_stop_req), .host_mode_select_call(host_mode_select_call),
  .logger_mode_selector(logger_mode_selector),
  .interface_mode_selector(interface_mode_selector), .power_led(power_led),
  .traffic_led(traffic_led), .logger_mode(logger_mode), .start_evt(start_evt),
  .stop_evt(stop_evt));
`default_nettype wire
